// File: core/iapg_top.sv
// indirect register page with video pattern generator
`timescale 1ns/1ps
// Operation
// - three main registers at 0xB0-0xB2 give access
// - auto-increment writes go to current then following offsets
// - auto-increment reads return current then following offsets
// - auto-increment advances offset after each data access
// - page field bits 5:2, page 0 generator
// - other page codes read zero and ignore writes
// - control bit 0 enables generator, resets off
// - config bit 7 picks fixed or colour bars
// - bits 5:4 give 1, 2, 4, 8 bars
// - bits 3:0 give fixed block size in bytes
// - bits 7:6 give packet virtual channel
// - bits 5:0 give packet data type
// - sixteen bit active line length in bytes
// - last bar fills the rest of line
// - line period counted in 10 ns units
// - active lines and total lines per frame
module iapg_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // main register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // packet header
  output logic pkt_hdr_valid,
  output logic [1:0] pkt_vc,
  output logic [5:0] pkt_dt,
  output logic [15:0] pkt_word_count,
  // payload stream
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic frame_start,
  output logic frame_end,
  output logic gen_active
);
  logic [7:0] ind_ctl_q;
  logic [7:0] ind_ofs_q;
  logic [7:0] pg_q [iapg_pkg::P0_FIRST:iapg_pkg::P0_LAST];
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic [3:0] page;
  logic autoinc;
  logic data_acc;

  function automatic logic [7:0] p0_reset(input int idx);
    case (idx)
      1: p0_reset = iapg_pkg::RST_CTL;
      2: p0_reset = iapg_pkg::RST_CFG;
      3: p0_reset = iapg_pkg::RST_IDENT;
      4: p0_reset = iapg_pkg::RST_LINE_HI;
      5: p0_reset = iapg_pkg::RST_LINE_LO;
      6: p0_reset = iapg_pkg::RST_BAR_HI;
      7: p0_reset = iapg_pkg::RST_BAR_LO;
      8: p0_reset = iapg_pkg::RST_ACT_HI;
      9: p0_reset = iapg_pkg::RST_ACT_LO;
      10: p0_reset = iapg_pkg::RST_TOT_HI;
      11: p0_reset = iapg_pkg::RST_TOT_LO;
      12: p0_reset = iapg_pkg::RST_PD_HI;
      default: p0_reset = iapg_pkg::RST_PD_LO;
    endcase
  endfunction : p0_reset

  // true when the page and offset name a stored page 0 register
  function automatic logic p0_hit(input logic [3:0] pg, input logic [7:0] ofs);
    p0_hit = (pg == iapg_pkg::PAGE_DIGITAL) && (ofs >= 8'(iapg_pkg::P0_FIRST))
      && (ofs <= 8'(iapg_pkg::P0_LAST));
  endfunction : p0_hit

  assign page = ind_ctl_q[iapg_pkg::CTL_PAGE_MSB:iapg_pkg::CTL_PAGE_LSB];
  assign autoinc = ind_ctl_q[iapg_pkg::CTL_AUTOINC_BIT];
  assign data_acc = (reg_wr || reg_rd) && (reg_addr == iapg_pkg::MAIN_IND_DAT);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ind_ctl_q <= iapg_pkg::CTL_RST;
    end else if (reg_wr && reg_addr == iapg_pkg::MAIN_IND_CTL) begin
      ind_ctl_q <= reg_wdata & iapg_pkg::CTL_WR_MASK;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ind_ofs_q <= iapg_pkg::OFS_RST;
    end else if (reg_wr && reg_addr == iapg_pkg::MAIN_IND_OFS) begin
      ind_ofs_q <= reg_wdata;
    end else if (data_acc && autoinc) begin
      ind_ofs_q <= ind_ofs_q + 8'h01;
    end
  end
  // without auto-increment the offset simply holds

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = iapg_pkg::P0_FIRST; i <= iapg_pkg::P0_LAST; i++) begin
        pg_q[i] <= p0_reset(i);
      end
    end else if (reg_wr && reg_addr == iapg_pkg::MAIN_IND_DAT && p0_hit(page, ind_ofs_q)) begin
      pg_q[ind_ofs_q[3:0]] <= reg_wdata;
    end
  end

  // register reads; data port returns the addressed indirect byte
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        if (reg_addr == iapg_pkg::MAIN_IND_CTL) begin
          rdata_q <= ind_ctl_q;
        end else if (reg_addr == iapg_pkg::MAIN_IND_OFS) begin
          rdata_q <= ind_ofs_q;
        end else if (reg_addr == iapg_pkg::MAIN_IND_DAT && p0_hit(page, ind_ofs_q)) begin
          rdata_q <= pg_q[ind_ofs_q[3:0]];
        end else begin
          rdata_q <= 8'h00;
        end
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;

  // decoded configuration
  logic gen_on;
  logic fixed_mode;
  logic [1:0] bar_count;
  logic [3:0] block_size;
  logic [15:0] active_line_bytes;
  logic [15:0] bar_length_bytes;
  logic [15:0] active_lines_per_frame;
  logic [15:0] total_lines;
  logic [15:0] line_period_count;
  logic [2:0] last_bar;
  logic [3:0] block_last;

  assign gen_on = pg_q[1][iapg_pkg::CTL_ON_BIT];
  assign fixed_mode = pg_q[2][iapg_pkg::CFG_FIXED_BIT];
  assign bar_count = pg_q[2][iapg_pkg::CFG_BARS_LSB +: 2];
  assign block_size = pg_q[2][iapg_pkg::CFG_BLOCK_LSB +: 4];
  assign active_line_bytes = {pg_q[4], pg_q[5]};
  assign bar_length_bytes = {pg_q[6], pg_q[7]};
  assign active_lines_per_frame = {pg_q[8], pg_q[9]};
  assign total_lines = {pg_q[10], pg_q[11]};
  assign line_period_count = {pg_q[12], pg_q[13]};
  assign last_bar = 3'((4'h1 << bar_count) - 4'h1);
  // a block size of zero is not legal; treat it as one byte
  assign block_last = (block_size == 4'h0) ? 4'h0 : block_size - 4'h1;

  // 10 ns tick from the 5 ns clock
  logic [1:0] div_q;
  logic tick;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_q <= 2'h0;
    end else if (!gen_on || div_q == 2'(iapg_pkg::LINE_UNIT_CYC - 1)) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end
  assign tick = gen_on && (div_q == 2'(iapg_pkg::LINE_UNIT_CYC - 1));

  // line period timer and line counter
  logic [15:0] period_q;
  logic [15:0] line_q;
  logic line_wrap;
  logic line_begin;
  logic start_q;
  assign line_wrap = tick && (period_q + 16'h0001 >= line_period_count);
  assign line_begin = start_q || line_wrap;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      start_q <= 1'b0;
    end else begin
      start_q <= gen_on && !gen_active;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      period_q <= 16'h0000;
    end else if (!gen_on || line_wrap) begin
      period_q <= 16'h0000;
    end else if (tick) begin
      period_q <= period_q + 16'h0001;
    end
  end

  logic [15:0] next_line;
  assign next_line = (line_q + 16'h0001 >= total_lines) ? 16'h0000 : line_q + 16'h0001;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      line_q <= 16'h0000;
    end else if (!gen_on || start_q) begin
      line_q <= 16'h0000;
    end else if (line_wrap) begin
      line_q <= next_line;
    end
  end

  // line state machine
  iapg_pkg::iapg_state_t st_q;
  logic [15:0] byte_q;
  logic cur_active;
  logic last_byte;
  assign cur_active = (line_q < active_lines_per_frame);
  assign last_byte = (byte_q + 16'h0001 >= active_line_bytes);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= iapg_pkg::ST_IDLE;
      byte_q <= 16'h0000;
    end else if (!gen_on) begin
      st_q <= iapg_pkg::ST_IDLE;
      byte_q <= 16'h0000;
    end else begin
      case (st_q)
        iapg_pkg::ST_IDLE: begin
          if (line_begin) begin
            st_q <= cur_active ? iapg_pkg::ST_HEADER : iapg_pkg::ST_BLANK;
          end
        end
        iapg_pkg::ST_HEADER: begin
          byte_q <= 16'h0000;
          st_q <= (active_line_bytes == 16'h0000) ? iapg_pkg::ST_BLANK : iapg_pkg::ST_PAYLOAD;
        end
        iapg_pkg::ST_PAYLOAD: begin
          byte_q <= byte_q + 16'h0001;
          if (last_byte) begin
            st_q <= iapg_pkg::ST_BLANK;
          end
        end
        default: begin
          if (line_wrap) begin
            st_q <= (next_line < active_lines_per_frame) ? iapg_pkg::ST_HEADER
              : iapg_pkg::ST_BLANK;
          end
        end
      endcase
    end
  end

  assign gen_active = (st_q != iapg_pkg::ST_IDLE);

  // pattern position counters
  logic [2:0] bar_q;
  logic [15:0] bar_pos_q;
  logic [3:0] blk_pos_q;
  logic blk_q;
  logic [1:0] comp_q;
  logic pay;
  assign pay = (st_q == iapg_pkg::ST_PAYLOAD);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bar_q <= 3'h0;
      bar_pos_q <= 16'h0000;
    end else if (!pay) begin
      bar_q <= 3'h0;
      bar_pos_q <= 16'h0000;
    end else if (bar_pos_q + 16'h0001 >= bar_length_bytes && bar_q != last_bar) begin
      bar_q <= bar_q + 3'h1;
      bar_pos_q <= 16'h0000;
    end else begin
      bar_pos_q <= bar_pos_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      blk_pos_q <= 4'h0;
      blk_q <= 1'b0;
    end else if (!pay) begin
      blk_pos_q <= 4'h0;
      blk_q <= 1'b0;
    end else if (blk_pos_q >= block_last) begin
      blk_pos_q <= 4'h0;
      blk_q <= !blk_q;
    end else begin
      blk_pos_q <= blk_pos_q + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      comp_q <= 2'h0;
    end else if (!pay || comp_q == 2'(iapg_pkg::BYTES_PER_PIXEL - 1)) begin
      comp_q <= 2'h0;
    end else begin
      comp_q <= comp_q + 2'h1;
    end
  end

  // colour of one component of a bar: bars step white toward black
  function automatic logic [7:0] bar_byte(input logic [2:0] idx, input logic [1:0] comp);
    bar_byte = idx[comp] ? 8'h00 : 8'hFF;
  endfunction : bar_byte

  // output registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pkt_hdr_valid <= 1'b0;
      pkt_vc <= 2'h0;
      pkt_dt <= 6'h00;
      pkt_word_count <= 16'h0000;
    end else begin
      pkt_hdr_valid <= (st_q == iapg_pkg::ST_HEADER);
      if (st_q == iapg_pkg::ST_HEADER) begin
        pkt_vc <= pg_q[3][iapg_pkg::IDENT_VC_LSB +: 2];
        pkt_dt <= pg_q[3][iapg_pkg::IDENT_DT_LSB +: 6];
        pkt_word_count <= active_line_bytes;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
    end else begin
      byte_valid <= pay;
      if (pay) begin
        byte_data <= fixed_mode ? {8{blk_q}} : bar_byte(bar_q, comp_q);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frame_start <= 1'b0;
      frame_end <= 1'b0;
    end else begin
      frame_start <= (st_q == iapg_pkg::ST_HEADER) && (line_q == 16'h0000);
      frame_end <= pay && last_byte && (line_q + 16'h0001 == active_lines_per_frame);
    end
  end
endmodule : iapg_top

// File: dv/iapg_host.sv
// host model driving the main register port
`timescale 1ns/1ps
module iapg_host (
  // clock
  input wire logic clk_sys,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // released lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (reg_rvalid !== 1'b1 && n < 4);
    // a missing answer hands back unknown data so the caller's compare trips
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask : rd
endmodule : iapg_host

// File: dv/iapg_monitor.sv
// assertions on the register port and the pattern stream outputs
`timescale 1ns/1ps
module iapg_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // stream
  input wire logic pkt_hdr_valid,
  input wire logic [15:0] pkt_word_count,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic frame_start,
  input wire logic frame_end,
  input wire logic gen_active
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // payload bytes seen since the last header
  logic [15:0] cnt_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= 16'h0000;
    end else if (pkt_hdr_valid) begin
      cnt_q <= 16'h0000;
    end else if (byte_valid) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  // back to back reads are legal, so the answer simply follows the strobe by one cycle
  rvalid_pulse_a: assert property (reg_rd |=> reg_rvalid ##1 (reg_rvalid == $past(reg_rd)))
    else $error("read answer missing or too long");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without request");
  rdata_hold_a: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved without answer");
  unmapped_zero_a: assert property (
    reg_rd && (reg_addr < 8'hB0 || reg_addr > 8'hB2) |=> reg_rdata == 8'h00)
    else $error("unmapped main read not zero");
  first_byte_a: assert property (
    pkt_hdr_valid && pkt_word_count != 16'h0000 |=> byte_valid)
    else $error("payload does not follow header");
  byte_count_a: assert property (byte_valid |-> cnt_q < pkt_word_count)
    else $error("payload longer than line");
  line_length_a: assert property ($fell(byte_valid) |-> cnt_q == pkt_word_count)
    else $error("payload shorter than line");
  frame_start_a: assert property (frame_start |-> pkt_hdr_valid && gen_active)
    else $error("frame start off header");
  frame_end_a: assert property (frame_end |-> byte_valid ##1 !byte_valid)
    else $error("frame end off last byte");
  bar_value_a: assert property (
    byte_valid |-> byte_data == 8'h00 || byte_data == 8'hFF)
    else $error("payload byte outside pattern");
endmodule : iapg_monitor

// File: dv/tb_indirect_access_pattern_gen.sv
// testbench for the indirect register page and pattern stream
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_indirect_access_pattern_gen;
  logic clk_sys;
  logic rst;
  logic reg_wr, reg_rd, reg_rvalid, pkt_hdr_valid, byte_valid, frame_start, frame_end, gen_active;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, byte_data, rd_q;
  logic [1:0] pkt_vc;
  logic [5:0] pkt_dt;
  logic [15:0] pkt_word_count;
  int num_errors = 0;
  int tests_run = 0;
  time t_hdr;
  localparam logic [7:0] RST_TAB [13] = '{8'h00, 8'h33, 8'h24, 8'h07, 8'h80, 8'h00, 8'hF0,
    8'h01, 8'hE0, 8'h02, 8'h0D, 8'h0C, 8'h67};
  localparam logic [7:0] CFG_TAB [12] = '{8'h13, 8'hAA, 8'h00, 8'h0C, 8'h00, 8'h03, 8'h00,
    8'h02, 8'h00, 8'h03, 8'h00, 8'h20};
  iapg_top i_dut (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pkt_hdr_valid(pkt_hdr_valid), .pkt_vc(pkt_vc), .pkt_dt(pkt_dt),
    .pkt_word_count(pkt_word_count), .byte_valid(byte_valid), .byte_data(byte_data),
    .frame_start(frame_start), .frame_end(frame_end), .gen_active(gen_active));
  iapg_host i_host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  // 12 byte line: two bars of 3 and 9 bytes, or fixed blocks of 2 bytes
  function automatic logic [7:0] exp_byte(int i, logic fixed);
    int b;
    b = (i < 3) ? 0 : 1;
    if (fixed) return ((i / 2) % 2) ? 8'hFF : 8'h00;
    return b[i % 3] ? 8'h00 : 8'hFF;
  endfunction : exp_byte
  task automatic get_line(logic fs, logic fixed);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (pkt_hdr_valid !== 1'b1 && n < 600);
    t_hdr = $time;
    `CHK(n < 600, 1'b1)
    `CHK(frame_start, fs)
    `CHK(pkt_vc, 2'h2)
    `CHK(pkt_dt, 6'h2A)
    `CHK(pkt_word_count, 16'h000C)
    for (int i = 0; i < 12; i++) begin
      @(negedge clk_sys);
      `CHK(byte_valid, 1'b1)
      `CHK(byte_data, exp_byte(i, fixed))
      `CHK(frame_end, !fs && i == 11)
    end
    @(negedge clk_sys);
    `CHK(byte_valid, 1'b0)
  endtask : get_line
  task automatic t_reset();
    i_host.rd(8'hB0, rd_q);
    `CHK(rd_q, 8'h00)
    i_host.rd(8'hFB, rd_q);
    `CHK(rd_q, 8'h00)
    i_host.rd(8'h10, rd_q);
    `CHK(rd_q, 8'h00)
    i_host.wr(8'hB0, 8'h02);
    i_host.wr(8'hB1, 8'h01);
    for (int i = 0; i < 13; i++) begin
      i_host.rd(8'hB2, rd_q);
      `CHK(rd_q, RST_TAB[i])
    end
    i_host.rd(8'hB1, rd_q);
    `CHK(rd_q, 8'h0E)
    $display("reset test done");
  endtask : t_reset
  task automatic t_autoinc();
    i_host.wr(8'hB1, 8'h06);
    i_host.wr(8'hB2, 8'hA5);
    i_host.wr(8'hB2, 8'h07);
    i_host.wr(8'hB1, 8'h06);
    i_host.rd(8'hB2, rd_q);
    `CHK(rd_q, 8'hA5)
    i_host.rd(8'hB2, rd_q);
    `CHK(rd_q, 8'h07)
    i_host.rd(8'hB1, rd_q);
    `CHK(rd_q, 8'h08)
    $display("auto-increment test done");
  endtask : t_autoinc
  task automatic t_hold();
    i_host.wr(8'hB0, 8'h00);
    i_host.wr(8'hB1, 8'h02);
    i_host.wr(8'hB2, 8'h12);
    i_host.rd(8'hB2, rd_q);
    `CHK(rd_q, 8'h12)
    i_host.rd(8'hB2, rd_q);
    `CHK(rd_q, 8'h12)
    i_host.rd(8'hB1, rd_q);
    `CHK(rd_q, 8'h02)
    i_host.wr(8'hB0, 8'hFF);
    i_host.rd(8'hB0, rd_q);
    `CHK(rd_q, iapg_pkg::CTL_WR_MASK)
    $display("fixed offset test done");
  endtask : t_hold
  task automatic t_pages();
    for (int p = 1; p < 8; p++) begin
      // offset 02 is stored on page 0, so a page decode fault shows here
      i_host.wr(8'hB0, {2'b00, p[3:0], 2'b00});
      i_host.wr(8'hB1, 8'h02);
      i_host.wr(8'hB2, 8'h5A);
      i_host.rd(8'hB2, rd_q);
      `CHK(rd_q, 8'h00)
    end
    i_host.wr(8'hB0, 8'h00);
    i_host.wr(8'hB1, 8'h02);
    i_host.rd(8'hB2, rd_q);
    `CHK(rd_q, 8'h12)
    i_host.wr(8'hB1, 8'h0E);
    i_host.wr(8'hB2, 8'h5A);
    i_host.rd(8'hB2, rd_q);
    `CHK(rd_q, 8'h00)
    i_host.wr(8'hB1, 8'h00);
    i_host.rd(8'hB2, rd_q);
    `CHK(rd_q, 8'h00)
    $display("page test done");
  endtask : t_pages
  task automatic t_stream();
    time t0;
    i_host.wr(8'hB0, 8'h02);
    i_host.wr(8'hB1, 8'h02);
    for (int i = 0; i < 12; i++) i_host.wr(8'hB2, CFG_TAB[i]);
    i_host.wr(8'hB1, 8'h01);
    i_host.wr(8'hB2, 8'h01);
    get_line(1'b1, 1'b0);
    get_line(1'b0, 1'b0);
    t0 = t_hdr;
    i_host.wr(8'hB1, 8'h02);
    i_host.wr(8'hB2, 8'h82);
    get_line(1'b1, 1'b1);
    // line 1 to next line 0 spans two periods of 32 ticks of 10 ns
    `CHK(t_hdr - t0, 64'h280)
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    i_host.wr(8'hB1, 8'h01);
    i_host.rd(8'hB2, rd_q);
    `CHK(rd_q, 8'h00)
    `CHK(gen_active, 1'b0)
    $display("stream test done");
  endtask : t_stream
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    num_errors++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_autoinc();
    t_hold();
    t_pages();
    t_stream();
    summarize();
  end
endmodule : tb_indirect_access_pattern_gen
bind iapg_top iapg_monitor i_mon (.clk_sys(clk_sys), .rst(rst), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .pkt_hdr_valid(pkt_hdr_valid), .pkt_word_count(pkt_word_count), .byte_valid(byte_valid),
  .byte_data(byte_data), .frame_start(frame_start), .frame_end(frame_end),
  .gen_active(gen_active));

// File: include/iapg_pkg.sv
// constants for the indirect register page and pattern generator
package iapg_pkg;
  // main-space register port offsets
  localparam logic [7:0] MAIN_IND_CTL = 8'hB0;
  localparam logic [7:0] MAIN_IND_OFS = 8'hB1;
  localparam logic [7:0] MAIN_IND_DAT = 8'hB2;
  localparam logic [7:0] MAIN_RSVD_FB = 8'hFB;
  localparam logic [7:0] MAIN_RSVD_RST = 8'h00;
  // indirect_control fields
  localparam int CTL_PAGE_LSB = 2;
  localparam int CTL_PAGE_MSB = 5;
  localparam int CTL_AUTOINC_BIT = 1;
  localparam logic [7:0] CTL_WR_MASK = 8'h3E;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] OFS_RST = 8'h00;
  // page codes
  localparam logic [3:0] PAGE_DIGITAL = 4'h0;
  localparam logic [3:0] PAGE_LINK0 = 4'h1;
  localparam logic [3:0] PAGE_LINK1 = 4'h2;
  localparam logic [3:0] PAGE_SHARED = 4'h5;
  localparam logic [3:0] PAGE_LINK_ALL = 4'h6;
  localparam logic [3:0] PAGE_CSITX = 4'h7;
  // page 0 offsets
  localparam logic [7:0] P0_CTL = 8'h01;
  localparam logic [7:0] P0_CFG = 8'h02;
  localparam logic [7:0] P0_IDENT = 8'h03;
  localparam logic [7:0] P0_LINE_HI = 8'h04;
  localparam logic [7:0] P0_LINE_LO = 8'h05;
  localparam logic [7:0] P0_BAR_HI = 8'h06;
  localparam logic [7:0] P0_BAR_LO = 8'h07;
  localparam logic [7:0] P0_ACT_HI = 8'h08;
  localparam logic [7:0] P0_ACT_LO = 8'h09;
  localparam logic [7:0] P0_TOT_HI = 8'h0A;
  localparam logic [7:0] P0_TOT_LO = 8'h0B;
  localparam logic [7:0] P0_PD_HI = 8'h0C;
  localparam logic [7:0] P0_PD_LO = 8'h0D;
  localparam int P0_FIRST = 1;
  localparam int P0_LAST = 13;
  // page 0 reset values
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h33;
  localparam logic [7:0] RST_IDENT = 8'h24;
  localparam logic [7:0] RST_LINE_HI = 8'h07;
  localparam logic [7:0] RST_LINE_LO = 8'h80;
  localparam logic [7:0] RST_BAR_HI = 8'h00;
  localparam logic [7:0] RST_BAR_LO = 8'hF0;
  localparam logic [7:0] RST_ACT_HI = 8'h01;
  localparam logic [7:0] RST_ACT_LO = 8'hE0;
  localparam logic [7:0] RST_TOT_HI = 8'h02;
  localparam logic [7:0] RST_TOT_LO = 8'h0D;
  localparam logic [7:0] RST_PD_HI = 8'h0C;
  localparam logic [7:0] RST_PD_LO = 8'h67;
  // configuration fields
  localparam int CTL_ON_BIT = 0;
  localparam int CFG_FIXED_BIT = 7;
  localparam int CFG_BARS_LSB = 4;
  localparam int CFG_BLOCK_LSB = 0;
  localparam int IDENT_VC_LSB = 6;
  localparam int IDENT_DT_LSB = 0;
  // timing: line period unit is 10 ns, clock period 5 ns
  localparam int CLK_PERIOD_PS = 5000;
  localparam int LINE_UNIT_PS = 10000;
  localparam int LINE_UNIT_CYC = LINE_UNIT_PS / CLK_PERIOD_PS;
  localparam int BYTES_PER_PIXEL = 3;
  typedef enum logic [1:0] {ST_IDLE, ST_HEADER, ST_PAYLOAD, ST_BLANK} iapg_state_t;
endpackage : iapg_pkg
